// [ured_pkg.sv]
// Package for the receive error detection block: offsets, fields, reset values
package ured_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_RXBUF = 12'h008;
  localparam logic [11:0] ADDR_IMASK = 12'h00C;
  localparam logic [11:0] ADDR_ISTAT = 12'h010;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_RXEN_BIT = 3;
  localparam int CTRL_PAREN_BIT = 4;
  localparam int CTRL_PARODD_BIT = 5;
  localparam int CTRL_STOP2_BIT = 6;
  localparam int CTRL_LEN_LSB = 8;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [1:0] LEN_7 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_9 = 2'h2;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int ST_OVR = 0;
  localparam int ST_FRM = 1;
  localparam int ST_PAR = 2;
  localparam int ST_SUM = 3;
  localparam int ST_RXC = 4;
  // Interrupt status: receive request, overrun, framing, parity
  localparam int IRQ_W = 4;
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_FRM = 2;
  localparam int IRQ_PAR = 3;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [IRQ_W-1:0] IMASK_RESET = 4'h0;
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_DEFAULT = 115200;
  localparam int FRAME_MAX = 13;
endpackage : ured_pkg

// [ured_rx.sv]
// Receive shifter with overrun, framing and parity detection behind APB
`timescale 1ns/1ps
module ured_rx import ured_pkg::*; #(
  parameter int BAUD = BAUD_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic irq
);
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  localparam int DIV = CLK_HZ / BAUD;
  localparam logic [15:0] DIV_FULL = 16'(DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(DIV / 2 - 1);

  typedef enum logic [1:0] {
    URED_IDLE = 2'b00,
    URED_START = 2'b01,
    URED_DATA = 2'b10
  } ured_state_t;

  // Character length in bits for the length field; the spare code reads as nine
  function automatic logic [3:0] data_len(input logic [1:0] len);
    case (len)
      LEN_7: data_len = 4'h7;
      LEN_8: data_len = 4'h8;
      default: data_len = 4'h9;
    endcase
  endfunction : data_len

  // Bits after the start bit: character, optional parity, one or two stops
  function automatic logic [3:0] frame_bits(input logic [1:0] len, input logic paren, input logic stop2);
    frame_bits = data_len(len) + {3'h0, paren} + {3'h0, stop2} + 4'h1;
  endfunction : frame_bits

  // Character bits of a right-aligned frame, unused upper bits zero
  function automatic logic [8:0] char_bits(input logic [12:0] f, input logic [1:0] len);
    case (len)
      LEN_7: char_bits = {2'b00, f[6:0]};
      LEN_8: char_bits = {1'b0, f[7:0]};
      default: char_bits = f[8:0];
    endcase
  endfunction : char_bits

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic rx_s1_q, rx_s2_q;
  logic [10:0] ctrl_q;
  logic [IRQ_W-1:0] imask_q, istat_q, istat_d;
  logic ovr_q, frm_q, par_q, rxc_q;
  logic [8:0] rxbuf_q;
  logic [12:0] shreg_q;
  logic [3:0] cnt_q;
  logic [15:0] tick_q;
  ured_state_t state_q;
  logic [31:0] prdata_q;
  logic irq_q;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_stat = paddr == ADDR_STAT;
  wire hit_rxbuf = paddr == ADDR_RXBUF;
  wire hit_imask = paddr == ADDR_IMASK;
  wire hit_istat = paddr == ADDR_ISTAT;
  wire wr_ctrl = wr && hit_ctrl;
  wire rd_buf_low = rd && hit_rxbuf;
  wire [2:0] mode = ctrl_q[CTRL_MODE_LSB +: CTRL_MODE_W];
  wire rx_en = ctrl_q[CTRL_RXEN_BIT] && (mode != MODE_OFF);
  wire paren = ctrl_q[CTRL_PAREN_BIT];
  wire parodd = ctrl_q[CTRL_PARODD_BIT];
  wire stop2 = ctrl_q[CTRL_STOP2_BIT];
  wire [1:0] len = ctrl_q[CTRL_LEN_LSB +: 2];
  // Writing mode zero or enable zero is the clearing event
  wire clr_off = wr_ctrl && ((pwdata[CTRL_MODE_LSB +: CTRL_MODE_W] == MODE_OFF) || !pwdata[CTRL_RXEN_BIT]);
  wire tick = tick_q == 16'h0000;
  wire [3:0] nbits = frame_bits(len, paren, stop2);

  // ----------------------------------------
  // Frame alignment and checks
  // ----------------------------------------
  // Shifted in at the top, so a finished frame sits left-aligned in the shift register
  wire [12:0] shreg_next = {rx_s2_q, shreg_q[12:1]};
  // Judge the frame with the final bit included
  wire [12:0] frn = shreg_next >> (4'd13 - nbits);
  wire [3:0] dlen = data_len(len);
  wire [8:0] datn = char_bits(frn, len);
  wire par_rx = frn[dlen];
  wire [3:0] sp_pos = dlen + {3'h0, paren};
  wire stopn_ok = frn[sp_pos] && (!stop2 || frn[sp_pos + 4'h1]);
  wire parn_bad = paren && ((^datn ^ par_rx) != parodd);
  wire last_bit = (state_q == URED_DATA) && tick && (cnt_q == nbits - 4'h1);
  wire done = last_bit;
  wire ovr_hit = done && rxc_q;
  wire frm_hit = done && !stopn_ok;
  wire par_hit = done && parn_bad;
  // An overrunning frame leaves the receive request as it was
  wire rxreq_hit = done && !rxc_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ----------------------------------------
  // Receive shifter
  // ----------------------------------------
  // Restarting at half a bit on the start edge puts every later sample mid-bit
  wire start_edge = (state_q == URED_IDLE) && !rx_s2_q;
  wire [15:0] tick_d = start_edge ? DIV_HALF : tick ? DIV_FULL : tick_q - 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 16'h0000;
    end else if (rx_en) begin
      tick_q <= tick_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= URED_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 13'h0000;
    end else if (!rx_en) begin
      state_q <= URED_IDLE;
    end else begin
      case (state_q)
        URED_IDLE: begin
          if (start_edge) begin
            state_q <= URED_START;
          end
        end
        URED_START: begin
          // A glitch shorter than half a bit is not a start
          if (tick) begin
            state_q <= rx_s2_q ? URED_IDLE : URED_DATA;
            cnt_q <= 4'h0;
          end
        end
        URED_DATA: begin
          if (tick) begin
            shreg_q <= shreg_next;
            cnt_q <= cnt_q + 4'h1;
            if (last_bit) begin
              state_q <= URED_IDLE;
            end
          end
        end
        default: state_q <= URED_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Flags and buffer
  // ----------------------------------------
  // Detection wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_hit | (ovr_q & !clr_off);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_q <= 1'b0;
    end else begin
      frm_q <= frm_hit | (frm_q & !(clr_off | rd_buf_low));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q <= 1'b0;
    end else begin
      par_q <= par_hit | (par_q & !(clr_off | rd_buf_low));
    end
  end

  // Any read of the buffer counts as the low-byte read, since the bus moves whole words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_q <= 1'b0;
    end else begin
      rxc_q <= done | (rxc_q & !rd_buf_low);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_q <= 9'h000;
    end else if (done) begin
      rxbuf_q <= datn;
    end
  end

  wire err_sum = ovr_q | frm_q | par_q;

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_comb begin
    istat_d = istat_q;
    if (wr && hit_istat) begin
      istat_d = istat_d & ~pwdata[IRQ_W-1:0];
    end
    if (rxreq_hit) begin
      istat_d[IRQ_RX] = 1'b1;
    end
    if (ovr_hit) begin
      istat_d[IRQ_OVR] = 1'b1;
    end
    if (frm_hit) begin
      istat_d[IRQ_FRM] = 1'b1;
    end
    if (par_hit) begin
      istat_d[IRQ_PAR] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[10:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= IMASK_RESET;
    end else if (wr && hit_imask) begin
      imask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // Registered level request: irq follows a new mask one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q <= |(istat_d & imask_q);
    end
  end

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  wire [31:0] stat_w = {27'h0, rxc_q, err_sum, par_q, frm_q, ovr_q};
  // Unmapped offsets fall through to zero and raise no error
  wire [31:0] ctrl_rd = {21'h0, ctrl_q};
  wire [31:0] rxbuf_rd = {23'h0, rxbuf_q};
  wire [31:0] imask_rd = {28'h0, imask_q};
  wire [31:0] istat_rd = {28'h0, istat_q};
  wire [31:0] rmux = hit_ctrl ? ctrl_rd : hit_stat ? stat_w : hit_rxbuf ? rxbuf_rd :
                     hit_imask ? imask_rd : hit_istat ? istat_rd : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rmux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = irq_q;
endmodule : ured_rx

// [ured_rx_properties.sv]
// Assertions on the receive error block's bus and interrupt pins
`timescale 1ns/1ps
module ured_chk import ured_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic irq
);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access not ready");
  property p_err; psel && penable |-> !pslverr; endproperty
  a_err: assert property (p_err) else $error("slave error seen");
  property p_sum; rd_acc && paddr == ADDR_STAT |-> prdata[ST_SUM] == (|prdata[2:0]); endproperty
  a_sum: assert property (p_sum) else $error("error sum wrong");
  property p_hi; rd_acc && paddr == ADDR_STAT |-> prdata[31:5] == 27'h0; endproperty
  a_hi: assert property (p_hi) else $error("status high bits set");
  property p_ist; rd_acc && paddr == ADDR_ISTAT |-> prdata[31:IRQ_W] == 28'h0; endproperty
  a_ist: assert property (p_ist) else $error("request high bits set");
  property p_unm; rd_acc && paddr > ADDR_ISTAT |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  // A cleared mask must silence irq within two edges, since irq is registered
  property p_ioff; psel && penable && pwrite && paddr == ADDR_IMASK && pwdata[3:0] == 4'h0 |=> ##1 !irq; endproperty
  a_ioff: assert property (p_ioff) else $error("irq high while masked");
  property p_rst; disable iff (1'b0) !presetn |-> !irq && prdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
endmodule : ured_chk
bind ured_rx ured_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));

// [ured_tx_model.sv]
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module ured_tx_model #(
  parameter int CPB = 10
) (
  input wire logic pclk,
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic bit_out(input logic v);
    rxd <= v;
    repeat (CPB) @(posedge pclk);
  endtask : bit_out
  // par 0 none, 1 even, 2 odd; flip spoils parity, bad_stop sends low stops
  task automatic send(input logic [8:0] d, input int n, input int par, input bit flip, input int ns, input bit bad_stop);
    logic p;
    p = ^(d & ((9'h1 << n) - 9'h1)) ^ (par == 2) ^ flip;
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (par != 0) bit_out(p);
    for (int i = 0; i < ns; i++) bit_out(!bad_stop);
    // Line returns to idle high; one idle bit lets the flags settle
    bit_out(1'b1);
  endtask : send
endmodule : ured_tx_model

// [tb_top.sv]
// Bench: APB accesses and serial frames checked against the receive error flags
`timescale 1ns/1ps
module tb_top;
  import ured_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  ured_rx #(.BAUD(2000000)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .irq(irq));
  ured_tx_model #(.CPB(CLK_HZ / 2000000)) tx_u (.pclk(pclk), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
    checks_done++;
    if (seen !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, e, seen);
    end
  endtask : check
  // Idle cycle after each transfer keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask : rdchk
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
    rdchk("imask", ADDR_IMASK, 32'(IMASK_RESET));
    rdchk("unmapped", 12'h020, 32'h0);
    apb(1'b1, ADDR_IMASK, 32'hF);
    for (int l = 0; l < 3; l++) begin
      apb(1'b1, ADDR_CTRL, 32'h49 | (32'(l) << 8));
      tx_u.send(9'h1A5, 7 + l, 0, 1'b0, 2, 1'b0);
      check("irq", {31'h0, irq}, 32'h1);
      rdchk("stat", ADDR_STAT, 32'h10);
      rdchk("istat", ADDR_ISTAT, 32'h1);
      apb(1'b1, ADDR_ISTAT, 32'hF);
      rdchk("rxbuf", ADDR_RXBUF, 32'h1A5 & ((32'h1 << (7 + l)) - 32'h1));
      rdchk("stat", ADDR_STAT, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, 32'h119);
      tx_u.send(9'h03C, 8, 1, 1'b0, 1, 1'b0);
      apb(1'b1, ADDR_ISTAT, 32'hF);
      tx_u.send(9'h05A, 8, 1, 1'b0, 1, 1'b0);
      rdchk("stat", ADDR_STAT, 32'h19);
      rdchk("istat", ADDR_ISTAT, 32'h2);
      apb(1'b0, ADDR_RXBUF, 32'h0);
      rdchk("stat", ADDR_STAT, 32'h09);
      apb(1'b1, ADDR_CTRL, (k == 0) ? 32'h111 : 32'h118);
      rdchk("stat", ADDR_STAT, 32'h0);
      apb(1'b1, ADDR_ISTAT, 32'hF);
    end
    apb(1'b1, ADDR_CTRL, 32'h139);
    tx_u.send(9'h0C3, 8, 2, 1'b1, 1, 1'b0);
    rdchk("stat", ADDR_STAT, 32'h1C);
    rdchk("istat", ADDR_ISTAT, 32'h9);
    rdchk("rxbuf", ADDR_RXBUF, 32'h0C3);
    rdchk("stat", ADDR_STAT, 32'h0);
    apb(1'b1, ADDR_ISTAT, 32'hF);
    tx_u.send(9'h0C3, 8, 2, 1'b0, 1, 1'b1);
    rdchk("stat", ADDR_STAT, 32'h1A);
    apb(1'b1, ADDR_CTRL, 32'h131);
    rdchk("stat", ADDR_STAT, 32'h10);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IMASK, 32'h0);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    rdchk("istat", ADDR_ISTAT, 32'h5);
    apb(1'b1, ADDR_ISTAT, 32'hF);
    rdchk("istat", ADDR_ISTAT, 32'h0);
    final_report();
  end
endmodule : tb_top
